/* include/acs_pkg.sv */
package acs_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] OFF_CSR = 8'h00;
   localparam logic [7:0] OFF_TRG = 8'h04;
   localparam logic [7:0] OFF_RES_A = 8'h08;
   localparam logic [7:0] OFF_RES_B = 8'h0c;
   localparam logic [7:0] OFF_RES_C = 8'h10;
   localparam logic [7:0] OFF_RES_D = 8'h14;
   localparam int ADDR_W = 8;
   // Field positions of converter_control_status
   localparam int B_END = 7;
   localparam int B_IE = 6;
   localparam int B_GO = 5;
   localparam int B_SCAN = 4;
   localparam int B_SPD = 3;
   localparam int B_CH_HI = 2;
   // Field positions of the trigger control register
   localparam int B_EXTERNAL_TRIGGER_ENABLE = 7;
   localparam logic [7:0] TRG_FIXED_ONES = 8'h7e;
   localparam logic [7:0] CSR_RESET = 8'h00;
   // Result layout: data in bits 15 to 6
   localparam int RES_W = 10;
   localparam int RES_LSB = 6;
   localparam int NUM_RES = 4;
   // Conversion times in states; one state is one clock period
   localparam int STATE_CYC = 1;
   localparam int SLOW_FIRST_ST = 134;
   localparam int FAST_FIRST_ST = 70;
   localparam int SLOW_NEXT_ST = 128;
   localparam int FAST_NEXT_ST = 66;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] SLOW_FIRST_CYC = CNT_W'(SLOW_FIRST_ST * STATE_CYC);
   localparam logic [CNT_W-1:0] FAST_FIRST_CYC = CNT_W'(FAST_FIRST_ST * STATE_CYC);
   localparam logic [CNT_W-1:0] SLOW_NEXT_CYC = CNT_W'(SLOW_NEXT_ST * STATE_CYC);
   localparam logic [CNT_W-1:0] FAST_NEXT_CYC = CNT_W'(FAST_NEXT_ST * STATE_CYC);
   // Sequencer states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } acs_state_type;
endpackage : acs_pkg

/* include/acs_res_if.sv */
// Carries result writes and reads between the sequencer and the result store
interface acs_res_if;
   import acs_pkg::*;
   logic wr_en; // One-cycle write strobe
   logic [1:0] wr_idx; // Target result register
   logic [RES_W-1:0] wr_data; // Converted code
   logic [1:0] rd_idx; // Register to read
   logic [RES_W-1:0] rd_data; // Registered read data
   modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
   modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : acs_res_if

/* verilog/acs_result_store.sv */
// Four result registers, one per channel pair, with registered read data
module acs_result_store (
   input wire logic pclk,
   input wire logic presetn,
   acs_res_if.store res
);
   import acs_pkg::*;

   logic [RES_W-1:0] mem_q [NUM_RES]; // Stored codes

   // Write one entry per conversion end
   generate
      for (genvar i = 0; i < NUM_RES; i++) begin : g_ent
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_q[i] <= '0;
            end else if (res.wr_en && (res.wr_idx == 2'(i))) begin
               mem_q[i] <= res.wr_data;
            end
         end
      end
   endgenerate

   // Read data comes out of a register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res.rd_data <= '0;
      end else begin
         res.rd_data <= mem_q[res.rd_idx];
      end
   end
endmodule : acs_result_store

/* verilog/acs_top.sv */
module acs_top (
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [acs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Power control, same clock domain
   input wire logic standby_req,
   // External trigger pin
   input wire logic external_trigger_input,
   // Analog core
   input wire logic [acs_pkg::RES_W-1:0] analog_code,
   output logic [2:0] analog_channel,
   output logic analog_active,
   output logic analog_fast,
   // Interrupt request
   output logic conversion_done_irq
);
   import acs_pkg::*;

   // Control register fields
   logic conversion_end_flag_q; // End flag
   logic end_interrupt_enable_q; // Interrupt enable
   logic conversion_go_q; // Start bit
   logic scan_mode_q; // Mode select
   logic conversion_speed_select_q; // Speed select
   logic [2:0] channel_field_q; // Channel field
   logic external_trigger_enable_q; // Trigger enable
   logic trg_res0_q; // Plain read/write spare bit of trigger register
   logic end_read_armed_q; // Flag was read as one

   // Sequencer state
   acs_state_type state_q;
   logic [CNT_W-1:0] cnt_q; // Remaining cycles of this conversion
   logic [1:0] pos_q; // Position within the scan group
   logic [2:0] cur_ch_q; // Channel under conversion

   // Synchronisers
   logic [RES_W-1:0] code_s1_q; // First stage, read only by second
   logic [RES_W-1:0] code_s2_q; // Second stage
   logic [RES_W-1:0] code_s3_q; // Previous second-stage sample
   logic [RES_W-1:0] code_hold_q; // Last code seen steady for two cycles
   logic trg_s1_q; // First stage, read only by second
   logic trg_s2_q; // Stable trigger level
   logic trg_s3_q; // Delayed level for edge detection

   // Bus decode
   logic acc; // Access phase
   logic wr_acc; // Write takes effect
   logic rd_acc; // Read completes
   logic hit_csr; // Control/status address
   logic hit_trg; // Trigger control address
   logic hit_res; // Any result address
   logic mapped; // Address belongs to this block
   logic [7:0] csr_view; // Register image

   // Sequencer events
   logic trg_fall; // Falling edge on the trigger pin
   logic conv_end; // Current conversion finishes this cycle
   logic pass_end; // Last channel of a scan pass
   logic set_end; // Sets the end flag
   logic single_done; // Single conversion finished
   logic [CNT_W-1:0] first_cyc; // Time of a first conversion
   logic [CNT_W-1:0] next_cyc; // Time of a later scan conversion
   logic [2:0] start_ch; // Channel for a new start

   acs_res_if res ();

   acs_result_store u_store (
      .pclk(pclk),
      .presetn(presetn),
      .res(res)
   );

   // Access phase decode
   assign acc = psel && penable;
   assign wr_acc = acc && pwrite;
   assign rd_acc = acc && !pwrite;
   // Address match per register
   assign hit_csr = (paddr == OFF_CSR);
   assign hit_trg = (paddr == OFF_TRG);
   assign hit_res = (paddr == OFF_RES_A) || (paddr == OFF_RES_B) ||
      (paddr == OFF_RES_C) || (paddr == OFF_RES_D);
   assign mapped = hit_csr || hit_trg || hit_res;

   // No wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;

   // Register image of the control/status register
   always_comb begin
      // Start from the reset image, then lay in each field
      csr_view = CSR_RESET;
      csr_view[B_END] = conversion_end_flag_q;
      csr_view[B_IE] = end_interrupt_enable_q;
      csr_view[B_GO] = conversion_go_q;
      csr_view[B_SCAN] = scan_mode_q;
      csr_view[B_SPD] = conversion_speed_select_q;
      csr_view[B_CH_HI:0] = channel_field_q;
   end

   // Result register index follows the address in the setup cycle
   // Only meaningful while a result address is on the bus
   assign res.rd_idx = 2'(paddr[ADDR_W-1:2] - OFF_RES_A[ADDR_W-1:2]);

   // Read data mux; result words sit in bits 15 to 6
   always_comb begin
      // Zero outside a read access phase
      prdata = '0;
      if (rd_acc) begin
         if (hit_csr) begin
            // Control/status byte
            prdata[7:0] = csr_view;
         end else if (hit_trg) begin
            // Fixed ones, enable and spare bit
            prdata[7:0] = TRG_FIXED_ONES;
            prdata[B_EXTERNAL_TRIGGER_ENABLE] = external_trigger_enable_q;
            prdata[0] = trg_res0_q;
         end else if (hit_res) begin
            // Result word, low six bits zero
            prdata[RES_LSB +: RES_W] = res.rd_data;
         end
      end
   end

   // Two-flop synchronisers for pin inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_s1_q <= '0;
         code_s2_q <= '0;
         code_s3_q <= '0;
         // Trigger stages idle high so release of reset gives no false edge
         trg_s1_q <= 1'b1;
         trg_s2_q <= 1'b1;
         trg_s3_q <= 1'b1;
      end else begin
         code_s1_q <= analog_code;
         code_s2_q <= code_s1_q;
         code_s3_q <= code_s2_q;
         trg_s1_q <= external_trigger_input;
         trg_s2_q <= trg_s1_q;
         trg_s3_q <= trg_s2_q;
      end
   end

   // Holds the code only once two samples agree, so a word caught changing is never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_hold_q <= '0;
      end else if (code_s2_q == code_s3_q) begin
         // Steady for two cycles: safe to take
         code_hold_q <= code_s3_q;
      end
   end

   // Falling edge seen on the synchronised trigger
   assign trg_fall = external_trigger_enable_q && trg_s3_q && !trg_s2_q;

   // Conversion time by speed select
   assign first_cyc = conversion_speed_select_q ? FAST_FIRST_CYC : SLOW_FIRST_CYC;
   assign next_cyc = conversion_speed_select_q ? FAST_NEXT_CYC : SLOW_NEXT_CYC;

   // First channel: direct in single mode, group base in scan mode
   assign start_ch = scan_mode_q ? {channel_field_q[B_CH_HI], 2'b00} :
      channel_field_q;

   // End of the conversion in progress
   assign conv_end = (state_q == ST_CONV) && conversion_go_q && (cnt_q == CNT_W'(1));
   // Pass ends when the position reaches the count field
   assign pass_end = scan_mode_q && (pos_q == channel_field_q[1:0]);
   // Single mode ends at every conversion
   assign single_done = conv_end && !scan_mode_q;
   assign set_end = single_done || (conv_end && pass_end);

   // Sequencer: counts conversion time and walks the channels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Idle on channel 0 with nothing counted
         state_q <= ST_IDLE;
         cnt_q <= '0;
         pos_q <= '0;
         cur_ch_q <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               // Start in the selected mode once the go bit is set
               if (conversion_go_q) begin
                  state_q <= ST_CONV;
                  cnt_q <= first_cyc;
                  pos_q <= '0;
                  cur_ch_q <= start_ch;
               end
            end
            ST_CONV: begin
               if (!conversion_go_q) begin
                  // Go cleared by software or standby: stop, no result
                  state_q <= ST_IDLE;
               end else if (conv_end) begin
                  if (!scan_mode_q) begin
                     state_q <= ST_IDLE;
                  end else if (pass_end) begin
                     // Restart at the group's first input
                     pos_q <= '0;
                     cur_ch_q <= {channel_field_q[B_CH_HI], 2'b00};
                     cnt_q <= next_cyc;
                  end else begin
                     // Next channel of the pass
                     pos_q <= pos_q + 2'd1;
                     cur_ch_q <= {channel_field_q[B_CH_HI], pos_q + 2'd1};
                     cnt_q <= next_cyc;
                  end
               end else begin
                  // Count down one cycle
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
         endcase
      end
   end

   // Result write at each conversion end; pair index is low channel bits
   assign res.wr_en = conv_end;
   assign res.wr_idx = cur_ch_q[1:0];
   assign res.wr_data = code_hold_q;

   // Start bit: software, trigger, automatic clear, standby
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // No conversion after reset
         conversion_go_q <= 1'b0;
      end else if (standby_req) begin
         // Standby stops any conversion
         conversion_go_q <= 1'b0;
      end else if (trg_fall) begin
         // Trigger edge wins over a software write
         conversion_go_q <= 1'b1;
      end else if (wr_acc && hit_csr) begin
         // Software start or stop
         conversion_go_q <= pwdata[B_GO];
      end else if (single_done) begin
         // Automatic clear at the end of a single conversion
         conversion_go_q <= 1'b0;
      end
   end

   // Plain control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Single mode, channel 0, slow, interrupt off
         end_interrupt_enable_q <= 1'b0;
         scan_mode_q <= 1'b0;
         conversion_speed_select_q <= 1'b0;
         channel_field_q <= '0;
      end else if (standby_req) begin
         // Standby returns the fields to reset values
         end_interrupt_enable_q <= 1'b0;
         scan_mode_q <= 1'b0;
         conversion_speed_select_q <= 1'b0;
         channel_field_q <= '0;
      end else if (wr_acc && hit_csr) begin
         // Software write of the control byte
         end_interrupt_enable_q <= pwdata[B_IE];
         scan_mode_q <= pwdata[B_SCAN];
         conversion_speed_select_q <= pwdata[B_SPD];
         channel_field_q <= pwdata[B_CH_HI:0];
      end
   end

   // Trigger control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Trigger off, spare bit clear
         external_trigger_enable_q <= 1'b0;
         trg_res0_q <= 1'b0;
      end else if (wr_acc && hit_trg) begin
         // Enable and spare bit are plain read/write
         external_trigger_enable_q <= pwdata[B_EXTERNAL_TRIGGER_ENABLE];
         trg_res0_q <= pwdata[0];
      end
   end

   // Remembers a read of the end flag as one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Nothing read yet
         end_read_armed_q <= 1'b0;
      end else if (standby_req) begin
         // Standby forgets the read
         end_read_armed_q <= 1'b0;
      end else if (wr_acc && hit_csr) begin
         // Any control write uses up the read
         end_read_armed_q <= 1'b0;
      end else if (rd_acc && hit_csr && conversion_end_flag_q) begin
         // Flag seen as one by software
         end_read_armed_q <= 1'b1;
      end
   end

   // End flag: hardware set wins over the software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // No conversion finished yet
         conversion_end_flag_q <= 1'b0;
      end else if (set_end) begin
         // Conversion or pass end, wins over any clear
         conversion_end_flag_q <= 1'b1;
      end else if (standby_req) begin
         // Standby clears the flag
         conversion_end_flag_q <= 1'b0;
      end else if (wr_acc && hit_csr && !pwdata[B_END] && end_read_armed_q) begin
         // Zero written after a read of one
         conversion_end_flag_q <= 1'b0;
      end
   end

   // Interrupt request and analog core controls
   assign conversion_done_irq = conversion_end_flag_q && end_interrupt_enable_q;
   // Analog core follows the sequencer
   assign analog_channel = cur_ch_q;
   assign analog_active = (state_q == ST_CONV);
   // Speed select passes straight to the core
   assign analog_fast = conversion_speed_select_q;
endmodule : acs_top

/* test/acs_top_chk.sv */
// Watches the converter control block from its top-level pins
module acs_top_chk
   import acs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic standby_req,
   input wire logic external_trigger_input,
   input wire logic [RES_W-1:0] analog_code,
   input wire logic [2:0] analog_channel,
   input wire logic analog_active,
   input wire logic analog_fast,
   input wire logic conversion_done_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic csr_wr; // Control register write taken this edge
   logic [15:0] run_cnt_q; // Length of the current active run
   logic [1:0] hit_q; // Control register writes or standby seen at the last two edges
   logic [15:0] slow_len; // Single conversion length, slow setting
   logic [15:0] fast_len; // Single conversion length, fast setting
   assign csr_wr = psel && penable && pwrite && paddr == OFF_CSR;
   assign slow_len = {8'h00, SLOW_FIRST_CYC};
   assign fast_len = {8'h00, FAST_FIRST_CYC};
   // Counts active cycles and remembers recent software or power events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cnt_q <= 16'h0;
         hit_q <= 2'b00;
      end else begin
         run_cnt_q <= analog_active ? run_cnt_q + 16'h1 : 16'h0;
         hit_q <= {hit_q[0], csr_wr || standby_req};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_start; csr_wr && pwdata[B_GO] && !standby_req |-> ##2 analog_active; endproperty
   a_start: assert property (p_start) else $error("go did not start");
   property p_single_ch;
      csr_wr && pwdata[B_GO] && !pwdata[B_SCAN] && !standby_req
         |-> ##2 analog_channel == $past(pwdata[2:0], 2);
   endproperty
   a_single_ch: assert property (p_single_ch) else $error("wrong single channel");
   property p_scan_ch;
      csr_wr && pwdata[B_GO] && pwdata[B_SCAN] && !standby_req
         |-> ##2 analog_channel == {$past(pwdata[B_CH_HI], 2), 2'b00};
   endproperty
   a_scan_ch: assert property (p_scan_ch) else $error("scan not at group start");
   property p_speed; csr_wr && !standby_req |=> analog_fast == $past(pwdata[B_SPD]); endproperty
   a_speed: assert property (p_speed) else $error("speed copy wrong");
   property p_len;
      $fell(analog_active) && hit_q == 2'b00 |-> run_cnt_q == (analog_fast ? fast_len : slow_len);
   endproperty
   a_len: assert property (p_len) else $error("conversion length wrong");
   property p_irq_set;
      $rose(conversion_done_irq) && !$past(csr_wr) |-> $past(analog_active);
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("irq without conversion");
   property p_irq_clr;
      $fell(conversion_done_irq) |-> $past(csr_wr) || $past(standby_req);
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq dropped alone");
   property p_standby;
      standby_req |=> !conversion_done_irq ##1 !analog_active;
   endproperty
   a_standby: assert property (p_standby) else $error("standby did not stop");
   property p_res;
      psel && penable && !pwrite && paddr >= OFF_RES_A && paddr <= OFF_RES_D
         |-> prdata[5:0] == 6'h0 && prdata[31:16] == 16'h0;
   endproperty
   a_res: assert property (p_res) else $error("result layout wrong");
   c_single: cover property ($fell(analog_active) && hit_q == 2'b00);
   c_irq: cover property ($rose(conversion_done_irq));
   c_err: cover property (penable && pslverr);
endmodule // acs_top_chk
bind acs_top acs_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .standby_req(standby_req), .external_trigger_input(external_trigger_input),
   .analog_code(analog_code), .analog_channel(analog_channel), .analog_active(analog_active),
   .analog_fast(analog_fast), .conversion_done_irq(conversion_done_irq));

/* test/acs_top_tb.sv */
module acs_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import acs_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, standby_req, external_trigger_input;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, analog_active, analog_fast, conversion_done_irq;
   logic [RES_W-1:0] analog_code, code; // Code on the pins, and its copy for expectations
   logic [2:0] analog_channel;
   int bad_count = 0;
   int n_tests = 0;
   int seed = 32'hf5ec;
   // Expected outcome of one bus transfer
   typedef struct {logic [31:0] data; logic err; logic rd;} acs_note_type;
   acs_note_type notes_q[$];
   acs_note_type note;
   acs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .standby_req(standby_req),
      .external_trigger_input(external_trigger_input),
      .analog_code(analog_code), .analog_channel(analog_channel), .analog_active(analog_active),
      .analog_fast(analog_fast), .conversion_done_irq(conversion_done_irq));
   // Free-running 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Counts one comparison and reports a difference
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Interrupt pin, looked at once the last edge has landed
   task automatic chk_irq(input logic exp);
      @(posedge pclk);
      chk("irq", {31'h0, exp}, {31'h0, conversion_done_irq});
   endtask
   // Verdict and end of run
   task automatic close_out();
      if (bad_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One bus transfer; its expected outcome goes to the queue first
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic err);
      notes_q.push_back('{exp, err, !w});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, exp, 1'b0);
   endtask
   // Bounded wait for an activity level, and for a channel while active
   task automatic wait_for(input logic [2:0] ch, input logic act);
      for (int n = 0; n < 2000; n++) begin
         @(posedge pclk);
         if (analog_active === act && (!act || analog_channel === ch)) return;
      end
      chk("wait", {28'h0, act, ch}, {28'h0, analog_active, analog_channel});
   endtask
   // Compares each taken transfer with the oldest note
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         note = notes_q.pop_front();
         if (note.rd) chk("prdata", note.data, prdata);
         chk("pslverr", {31'h0, note.err}, {31'h0, pslverr});
      end
   end
   // Cuts a hang short
   initial begin
      #300000;
      bad_count++;
      close_out();
   end
   initial begin
      {psel, penable, pwrite, standby_req, presetn} = 5'h0;
      {paddr, pwdata, analog_code} = '0;
      external_trigger_input = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFF_CSR, 32'h0);
      rd(OFF_TRG, {24'h0, TRG_FIXED_ONES});
      apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
      // Single conversion on every input, speed alternating
      for (int ch = 0; ch < 8; ch++) begin
         code = RES_W'($random(seed));
         analog_code <= code;
         wr(OFF_CSR, {24'h0, 3'b001, 1'b0, ch[0], 3'(ch)});
         wait_for(3'(ch), 1'b1);
         wait_for(3'h0, 1'b0);
         rd(OFF_RES_A + 8'(4 * (ch % 4)), {16'h0, code, 6'h0});
         rd(OFF_CSR, {24'h0, 4'h8, ch[0], 3'(ch)});
      end
      // Fast scan over inputs 4 to 7 with the interrupt on
      wr(OFF_CSR, 32'h7f);
      for (int i = 0; i < 5; i++) begin
         wait_for(3'(4 + i % 4), 1'b1);
         if (i == 3) chk_irq(1'b0);
      end
      chk_irq(1'b1);
      wr(OFF_CSR, 32'h5f);
      wait_for(3'h0, 1'b0);
      rd(OFF_CSR, 32'hdf);
      wr(OFF_CSR, 32'hc8);
      wr(OFF_CSR, 32'h48);
      chk_irq(1'b1);
      rd(OFF_CSR, 32'hc8);
      wr(OFF_CSR, 32'h48);
      chk_irq(1'b0);
      wr(OFF_CSR, 32'hc8);
      chk_irq(1'b0);
      // Two-channel slow scan on group 0, then standby in mid-scan
      wr(OFF_CSR, 32'h31);
      wait_for(3'h0, 1'b1);
      wait_for(3'h1, 1'b1);
      wait_for(3'h0, 1'b1);
      rd(OFF_CSR, 32'hb1);
      standby_req <= 1'b1;
      @(posedge pclk);
      standby_req <= 1'b0;
      wait_for(3'h0, 1'b0);
      rd(OFF_CSR, 32'h0);
      // Start from the trigger pin, then unmapped write
      wr(OFF_TRG, 32'h80);
      wr(OFF_CSR, 32'h0b);
      external_trigger_input <= 1'b0;
      wait_for(3'h3, 1'b1);
      wait_for(3'h0, 1'b0);
      rd(OFF_CSR, 32'h8b);
      rd(OFF_TRG, 32'hfe);
      apb(1'b1, 8'h20, 32'hff, 32'h0, 1'b1);
      close_out();
   end
endmodule // acs_top_tb
